// [hw/sysmgmt_hold_map.vh]
// constants for the processor side-band control block
`ifndef SYSMGMT_HOLD_MAP_VH
`define SYSMGMT_HOLD_MAP_VH
`define SOFT_RESET_MIN_CYCLES 4'hf
`define SOFT_RESET_CNT_W      4
`define SYNC_STAGES           2
`define DRAIN_CYCLES          3'h4
`define DRAIN_CNT_W           3
`define BASE_REG_W            32
`define BASE_REG_RESET        32'h00030000
`define ST_RUN                7'h01
`define ST_SAVE               7'h02
`define ST_MGMT               7'h04
`define ST_RESTORE            7'h08
`define ST_STOP_DRAIN         7'h10
`define ST_STOP_ACK           7'h20
`define ST_STOPPED            7'h40
`define STATE_W               7
`endif

// [hw/sync_chain.v]
// two-stage synchroniser for one asynchronous level
`timescale 1ns/1ns
module sync_chain #(
    parameter RESET_VALUE = 1'b0
) (
    input  wire ref_clk,
    input  wire reset,
    input  wire asyncIn,
    output reg  syncOut
);
    reg firstStage;

    always @(posedge ref_clk) begin
        if (reset) begin
            firstStage <= RESET_VALUE;
            syncOut    <= RESET_VALUE;
        end else begin
            firstStage <= asyncIn;
            syncOut    <= firstStage;
        end
    end
endmodule

// [hw/bus_hold_arbiter.v]
// local bus hold arbitration with bus request and yield acknowledge
`timescale 1ns/1ns
module bus_hold_arbiter (
    input  wire ref_clk,
    input  wire reset,
    input  wire holdRequest,
    input  wire cycleActive,
    input  wire lockedSeq,
    input  wire internal_bus_request,
    output reg  busRequestOut,
    output reg  bus_yield_ack,
    output reg  busFloat
);
    // hold request is synchronous from the other master, so it is used directly
    wire grantNow = holdRequest & ~cycleActive & ~lockedSeq;

    always @(posedge ref_clk) begin
        if (reset) begin
            busRequestOut <= 1'b0;
            bus_yield_ack <= 1'b0;
            busFloat      <= 1'b0;
        end else begin
            busRequestOut <= internal_bus_request;
            if (!bus_yield_ack) begin
                bus_yield_ack <= grantNow;
                busFloat      <= grantNow;
            end else begin
                bus_yield_ack <= holdRequest;
                busFloat      <= holdRequest;
            end
        end
    end
endmodule

// [hw/cpu_sysmgmt_hold_control.v]
// processor side-band control: soft reset, management interrupt, stop clock, bus hold
//
// Summary of operation
// - hard reset starts from a known state
// - soft reset acts as reset, keeps base
// - soft reset active high, asynchronous, sampled
// - falling interrupt edge enters management mode
// - interrupt taken only at instruction boundaries
// - no entry during locked cycles or management
// - one further edge latched while servicing
// - nested interrupt waits for resume instruction
// - active output asserted at state save
// - active output released after final restore
// - stop request halts at next boundary with no higher interrupt pending
// - drain buffers then issue stop acknowledge
// - bus request output follows internal request
// - hold granted after current cycle and any locked sequence end
// - hold kept while hold request stays high
// - yield acknowledge with bus float clock
// - acknowledge dropped on leaving hold, driven
`timescale 1ns/1ns
`include "sysmgmt_hold_map.vh"
module cpu_sysmgmt_hold_control #(
    parameter SAVE_CYCLES    = 8,
    parameter RESTORE_CYCLES = 8
) (
    input  wire                   ref_clk,
    input  wire                   reset,
    input  wire                   soft_reset_in,
    input  wire                   sys_mgmt_interrupt_n,
    input  wire                   stop_clock_request_n,
    input  wire                   holdRequest,
    input  wire                   instrBoundary,
    input  wire                   lockedSeq,
    input  wire                   cycleActive,
    input  wire                   higherIntPending,
    input  wire                   resume_from_mgmt_instr,
    input  wire                   buffersEmpty,
    input  wire                   internal_bus_request,
    input  wire                   baseWriteEn,
    input  wire [`BASE_REG_W-1:0] baseWriteData,
    output reg                    coreReset,
    output reg                    sys_mgmt_active_n,
    output reg                    system_mgmt_mode,
    output reg                    stopAckCycle,
    output reg                    execHalted,
    output reg  [`BASE_REG_W-1:0] sysmgmt_base_reg,
    output wire                   busRequestOut,
    output wire                   bus_yield_ack,
    output wire                   busFloat
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    wire softResetSync;
    wire mgmtIntSync;
    wire stopReqSync;

    sync_chain #(.RESET_VALUE(1'b0)) u_sync_soft_reset_in (
        .ref_clk (ref_clk),
        .reset   (reset),
        .asyncIn (soft_reset_in),
        .syncOut (softResetSync)
    );
    sync_chain #(.RESET_VALUE(1'b1)) u_sync_smi (
        .ref_clk (ref_clk),
        .reset   (reset),
        .asyncIn (sys_mgmt_interrupt_n),
        .syncOut (mgmtIntSync)
    );
    sync_chain #(.RESET_VALUE(1'b1)) u_sync_stop (
        .ref_clk (ref_clk),
        .reset   (reset),
        .asyncIn (stop_clock_request_n),
        .syncOut (stopReqSync)
    );

    // ------------------------------------------------------------
    // soft reset qualification
    // ------------------------------------------------------------
    // a pulse shorter than the minimum is ignored; the system must hold it long enough
    reg [`SOFT_RESET_CNT_W-1:0] softCount;
    wire softResetQual = softResetSync && (softCount == `SOFT_RESET_MIN_CYCLES);
    wire anyReset      = reset | softResetQual;

    always @(posedge ref_clk) begin
        if (reset || !softResetSync) begin
            softCount <= {`SOFT_RESET_CNT_W{1'b0}};
        end else if (softCount != `SOFT_RESET_MIN_CYCLES) begin
            softCount <= softCount + {{(`SOFT_RESET_CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge ref_clk) begin
        coreReset <= anyReset;
    end

    // base register survives soft reset, only a hard reset sets it back
    always @(posedge ref_clk) begin
        if (reset) begin
            sysmgmt_base_reg <= `BASE_REG_RESET;
        end else if (baseWriteEn && !softResetQual) begin
            sysmgmt_base_reg <= baseWriteData;
        end
    end

    // ------------------------------------------------------------
    // management interrupt edge capture
    // ------------------------------------------------------------
    reg mgmtIntPrev;
    reg mgmtPending;
    wire mgmtFall = mgmtIntPrev & ~mgmtIntSync;

    reg [`STATE_W-1:0] state;
    reg [`STATE_W-1:0] next_state;
    reg [7:0]          phaseCount;
    reg [`DRAIN_CNT_W-1:0] drainCount;

    wire takeMgmt = mgmtPending && instrBoundary && !lockedSeq;
    wire takeStop = !stopReqSync && instrBoundary && !higherIntPending;

    always @(posedge ref_clk) begin
        if (anyReset) begin
            // follow the synchronised pin so a soft reset with the pin low makes no false edge
            mgmtIntPrev <= mgmtIntSync;
            mgmtPending <= 1'b0;
        end else begin
            mgmtIntPrev <= mgmtIntSync;
            // a new edge wins over the clear when both fall in one cycle
            if (mgmtFall) begin
                mgmtPending <= 1'b1;
            end else if (state == `ST_RUN && takeMgmt) begin
                mgmtPending <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // control sequencer
    // ------------------------------------------------------------
    always @* begin
        next_state = state;
        case (state)
            `ST_RUN: begin
                if (takeMgmt) begin
                    next_state = `ST_SAVE;
                end else if (takeStop) begin
                    next_state = `ST_STOP_DRAIN;
                end
            end
            `ST_SAVE: begin
                if (phaseCount == SAVE_CYCLES[7:0] - 8'h01) begin
                    next_state = `ST_MGMT;
                end
            end
            `ST_MGMT: begin
                // pending edge stays latched here; no nesting before resume
                if (resume_from_mgmt_instr) begin
                    next_state = `ST_RESTORE;
                end
            end
            `ST_RESTORE: begin
                if (phaseCount == RESTORE_CYCLES[7:0] - 8'h01) begin
                    next_state = `ST_RUN;
                end
            end
            `ST_STOP_DRAIN: begin
                if (buffersEmpty && drainCount == `DRAIN_CYCLES) begin
                    next_state = `ST_STOP_ACK;
                end
            end
            `ST_STOP_ACK: begin
                next_state = `ST_STOPPED;
            end
            `ST_STOPPED: begin
                // request may drop any time after the acknowledge cycle
                if (stopReqSync) begin
                    next_state = `ST_RUN;
                end
            end
            default: begin
                next_state = `ST_RUN;
            end
        endcase
    end

    always @(posedge ref_clk) begin
        if (anyReset) begin
            state      <= `ST_RUN;
            phaseCount <= 8'h00;
            drainCount <= {`DRAIN_CNT_W{1'b0}};
        end else begin
            state <= next_state;
            if (next_state != state) begin
                phaseCount <= 8'h00;
            end else begin
                phaseCount <= phaseCount + 8'h01;
            end
            if (state != `ST_STOP_DRAIN) begin
                drainCount <= {`DRAIN_CNT_W{1'b0}};
            end else if (drainCount != `DRAIN_CYCLES) begin
                drainCount <= drainCount + {{(`DRAIN_CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (anyReset) begin
            sys_mgmt_active_n <= 1'b1;
            system_mgmt_mode  <= 1'b0;
            stopAckCycle      <= 1'b0;
            execHalted        <= 1'b0;
        end else begin
            // active from the first save cycle through the last restore cycle
            sys_mgmt_active_n <= ~(next_state == `ST_SAVE || next_state == `ST_MGMT ||
                                   next_state == `ST_RESTORE);
            system_mgmt_mode  <= (next_state == `ST_MGMT);
            stopAckCycle      <= (next_state == `ST_STOP_ACK);
            execHalted        <= (next_state == `ST_STOP_DRAIN || next_state == `ST_STOP_ACK ||
                                  next_state == `ST_STOPPED);
        end
    end

    // ------------------------------------------------------------
    // bus hold arbitration
    // ------------------------------------------------------------
    bus_hold_arbiter u_arbiter (
        .ref_clk              (ref_clk),
        .reset                (anyReset),
        .holdRequest          (holdRequest),
        .cycleActive          (cycleActive),
        .lockedSeq            (lockedSeq),
        .internal_bus_request (internal_bus_request),
        .busRequestOut        (busRequestOut),
        .bus_yield_ack        (bus_yield_ack),
        .busFloat             (busFloat)
    );
endmodule

// [verif/cpu_sysmgmt_hold_props.sv]
// concurrent checks for the processor side-band control block
`timescale 1ns/1ns
`include "sysmgmt_hold_map.vh"
module cpu_sysmgmt_hold_props #(
    parameter SAVE_CYCLES    = 8,
    parameter RESTORE_CYCLES = 8
) (
    input wire                   ref_clk,
    input wire                   reset,
    input wire                   soft_reset_in,
    input wire                   holdRequest,
    input wire                   instrBoundary,
    input wire                   lockedSeq,
    input wire                   cycleActive,
    input wire                   internal_bus_request,
    input wire                   baseWriteEn,
    input wire                   coreReset,
    input wire                   sys_mgmt_active_n,
    input wire                   system_mgmt_mode,
    input wire                   stopAckCycle,
    input wire                   execHalted,
    input wire [`BASE_REG_W-1:0] sysmgmt_base_reg,
    input wire                   busRequestOut,
    input wire                   bus_yield_ack,
    input wire                   busFloat
);
    // two spare cycles on each bound cover the entry and exit edges
    localparam int SAVE_MAX = SAVE_CYCLES + 2;
    localparam int RST_MAX  = RESTORE_CYCLES + 2;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence s_save;
        !system_mgmt_mode ##[1:SAVE_MAX] system_mgmt_mode;
    endsequence
    sequence s_restore;
        !sys_mgmt_active_n ##[1:RST_MAX] sys_mgmt_active_n;
    endsequence
    a_smi_boundary: assert property ($fell(sys_mgmt_active_n) |->
        $past(instrBoundary) && !$past(lockedSeq)) else $error("entry off boundary");
    a_save_first: assert property ($fell(sys_mgmt_active_n) |-> s_save)
        else $error("save phase wrong");
    a_restore_last: assert property ($fell(system_mgmt_mode) |-> s_restore)
        else $error("restore phase wrong");
    a_soft_filter: assert property ($rose(soft_reset_in) && !coreReset |->
        !coreReset [*8]) else $error("soft reset too fast");
    a_base_kept: assert property (coreReset && !$past(reset) && !$past(baseWriteEn)
        |-> $stable(sysmgmt_base_reg)) else $error("base lost on soft reset");
    a_bus_req: assert property (!$past(reset) |->
        busRequestOut == $past(internal_bus_request)) else $error("bus request wrong");
    a_stop_pulse: assert property (stopAckCycle |-> execHalted ##1 !stopAckCycle)
        else $error("stop ack wrong");
    a_hold_grant: assert property (!bus_yield_ack && holdRequest && !cycleActive
        && !lockedSeq |=> bus_yield_ack) else $error("hold not granted");
    a_hold_span: assert property (bus_yield_ack |=>
        bus_yield_ack == $past(holdRequest)) else $error("hold span wrong");
    a_float_ack: assert property (busFloat == bus_yield_ack)
        else $error("float and ack differ");
endmodule
bind cpu_sysmgmt_hold_control cpu_sysmgmt_hold_props #(
    .SAVE_CYCLES(SAVE_CYCLES),
    .RESTORE_CYCLES(RESTORE_CYCLES)
) i_props (
    .ref_clk, .reset, .soft_reset_in, .holdRequest, .instrBoundary, .lockedSeq,
    .cycleActive, .internal_bus_request, .baseWriteEn, .coreReset, .sys_mgmt_active_n,
    .system_mgmt_mode, .stopAckCycle, .execHalted, .sysmgmt_base_reg, .busRequestOut,
    .bus_yield_ack, .busFloat
);

// [verif/chipset_model.sv]
// far-side model: stop clock requester and alternate bus master
`timescale 1ns/1ns
module chipset_model (
    input  wire  ref_clk,
    input  wire  stopWant,
    input  wire  holdWant,
    input  wire  stopAckCycle,
    output logic stop_clock_request_n = 1'b1,
    output logic holdRequest = 1'b0
);
    logic acked = 1'b0;
    always @(posedge ref_clk) begin
        holdRequest <= holdWant;
        if (stopAckCycle)
            acked <= 1'b1;
        // the request is withdrawn only once the acknowledge was seen
        if (stopWant)
            stop_clock_request_n <= 1'b0;
        else if (acked) begin
            stop_clock_request_n <= 1'b1;
            acked <= 1'b0;
        end
    end
endmodule

// [verif/tb_top.sv]
// self-checking bench for the processor side-band control block
`timescale 1ns/1ns
`include "sysmgmt_hold_map.vh"
module tb_top;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic soft_reset_in = 1'b0;
    logic sys_mgmt_interrupt_n = 1'b1;
    logic instrBoundary = 1'b0, lockedSeq = 1'b0, cycleActive = 1'b0;
    logic higherIntPending = 1'b0, resume_from_mgmt_instr = 1'b0, buffersEmpty = 1'b1;
    logic internal_bus_request = 1'b0, baseWriteEn = 1'b0, stopWant = 1'b0, holdWant = 1'b0;
    logic [`BASE_REG_W-1:0] baseWriteData = 32'h00000000;
    wire stop_clock_request_n, holdRequest, coreReset, sys_mgmt_active_n, system_mgmt_mode;
    wire stopAckCycle, execHalted, busRequestOut, bus_yield_ack, busFloat;
    wire [`BASE_REG_W-1:0] sysmgmt_base_reg;
    int mismatches = 0, checks = 0, acks = 0, rstCyc = 0;
    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) acks <= acks + stopAckCycle;
    always @(posedge ref_clk) rstCyc <= rstCyc + coreReset;
    cpu_sysmgmt_hold_control #(.SAVE_CYCLES(2), .RESTORE_CYCLES(2)) i_dut (
        .ref_clk, .reset, .soft_reset_in, .sys_mgmt_interrupt_n, .stop_clock_request_n,
        .holdRequest, .instrBoundary, .lockedSeq, .cycleActive, .higherIntPending,
        .resume_from_mgmt_instr, .buffersEmpty, .internal_bus_request, .baseWriteEn,
        .baseWriteData, .coreReset, .sys_mgmt_active_n, .system_mgmt_mode, .stopAckCycle,
        .execHalted, .sysmgmt_base_reg, .busRequestOut, .bus_yield_ack, .busFloat
    );
    chipset_model i_far (.ref_clk, .stopWant, .holdWant, .stopAckCycle,
        .stop_clock_request_n, .holdRequest);
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic resume;
        @(posedge ref_clk);
        resume_from_mgmt_instr <= 1'b1;
        @(posedge ref_clk);
        resume_from_mgmt_instr <= 1'b0;
    endtask
    task automatic t_hold;
        @(posedge ref_clk);
        cycleActive <= 1'b1;
        lockedSeq <= 1'b1;
        holdWant <= 1'b1;
        internal_bus_request <= 1'b1;
        repeat (3) @(posedge ref_clk);
        cycleActive <= 1'b0;
        repeat (3) @(posedge ref_clk);
        lockedSeq <= 1'b0;
        #1 chk("ackLocked", 0, bus_yield_ack);
        repeat (2) @(posedge ref_clk);
        #1 chk("ack", 1, bus_yield_ack);
        chk("float", 1, busFloat);
        chk("busReq", 1, busRequestOut);
        repeat (4) @(posedge ref_clk);
        holdWant <= 1'b0;
        internal_bus_request <= 1'b0;
        #1 chk("ackHeld", 1, bus_yield_ack);
        repeat (3) @(posedge ref_clk);
        #1 chk("ackOff", 0, bus_yield_ack);
    endtask
    task automatic t_smi;
        @(posedge ref_clk);
        sys_mgmt_interrupt_n <= 1'b0;
        instrBoundary <= 1'b1;
        repeat (12) @(posedge ref_clk);
        instrBoundary <= 1'b0;
        sys_mgmt_interrupt_n <= 1'b1;
        #1 chk("mode", 1, system_mgmt_mode);
        chk("actIn", 0, sys_mgmt_active_n);
        repeat (3) @(posedge ref_clk);
        sys_mgmt_interrupt_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        sys_mgmt_interrupt_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        sys_mgmt_interrupt_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        resume;
        repeat (8) @(posedge ref_clk);
        instrBoundary <= 1'b1;
        #1 chk("actOut", 1, sys_mgmt_active_n);
        repeat (4) @(posedge ref_clk);
        #1 chk("nested", 0, sys_mgmt_active_n);
        repeat (4) @(posedge ref_clk);
        resume;
        repeat (12) @(posedge ref_clk);
        #1 chk("onlyOne", 1, sys_mgmt_active_n);
    endtask
    task automatic t_stop;
        int n;
        @(posedge ref_clk);
        buffersEmpty <= 1'b0;
        stopWant <= 1'b1;
        higherIntPending <= 1'b1;
        repeat (6) @(posedge ref_clk);
        higherIntPending <= 1'b0;
        #1 chk("blocked", 0, execHalted);
        repeat (8) @(posedge ref_clk);
        buffersEmpty <= 1'b1;
        #1 chk("halted", 1, execHalted);
        chk("ackEarly", 0, acks);
        n = 0;
        while (acks == 0 && n < 20) begin
            @(posedge ref_clk);
            #1 n++;
        end
        @(posedge ref_clk);
        stopWant <= 1'b0;
        #1 chk("ackOnce", 1, acks);
        repeat (6) @(posedge ref_clk);
        #1 chk("running", 0, execHalted);
    endtask
    task automatic t_soft;
        rstCyc = 0;
        @(posedge ref_clk);
        baseWriteEn <= 1'b1;
        baseWriteData <= 32'h0001a000;
        @(posedge ref_clk);
        baseWriteEn <= 1'b0;
        soft_reset_in <= 1'b1;
        repeat (6) @(posedge ref_clk);
        soft_reset_in <= 1'b0;
        repeat (4) @(posedge ref_clk);
        soft_reset_in <= 1'b1;
        #1 chk("shortSoft", 0, rstCyc);
        repeat (24) @(posedge ref_clk);
        soft_reset_in <= 1'b0;
        repeat (4) @(posedge ref_clk);
        reset <= 1'b1;
        #1 chk("softTaken", 1, rstCyc != 0);
        chk("baseKept", 32'h0001a000, sysmgmt_base_reg);
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 chk("baseHard", `BASE_REG_RESET, sysmgmt_base_reg);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1 chk("baseRst", `BASE_REG_RESET, sysmgmt_base_reg);
        t_hold;
        t_smi;
        t_stop;
        t_soft;
        final_report;
    end
    // the scenarios need under two hundred cycles; this allows twenty times that
    initial begin
        #200000;
        mismatches++;
        final_report;
    end
endmodule
